// ===== sflp_pkg.sv
// Constants and types shared by the fast-lock profile store.
// Assumes a 20 MHz system clock and a byte-wide host register port.
`default_nettype none
package sflp_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0] OFS_SETUP = 10'h29A;
    localparam logic [9:0] OFS_INIT_DELAY = 10'h29B;
    localparam logic [9:0] OFS_PROG_ADDR = 10'h29C;
    localparam logic [9:0] OFS_PROG_DATA = 10'h29D;
    localparam logic [9:0] OFS_READ_BACK = 10'h29E;
    localparam logic [9:0] OFS_PROG_CTRL = 10'h29F;
    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_SETUP = 8'h00;
    localparam logic [7:0] RST_INIT_DELAY = 8'h00;
    localparam logic [7:0] RST_PROG_ADDR = 8'h00;
    localparam logic [7:0] RST_PROG_DATA = 8'h00;
    localparam logic [7:0] RST_PROG_CTRL = 8'h00;
    localparam int SETUP_PROFILE_HI = 7;
    localparam int SETUP_PROFILE_LO = 5;
    localparam int SETUP_ENABLE_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_CLKEN_BIT = 0;
    localparam int NUM_PROFILES = 8;
    localparam int NUM_WORDS = 16;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int INIT_STEP_NS = 250;
    localparam int INIT_STEP_CYCLES = (INIT_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // ------------------------------------------------------------------
    // Decoded synthesizer setup
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [10:0] integerWord;
        logic [22:0] fractionalWord;
        logic [2:0] oscBiasRef;
        logic [3:0] oscVaractor;
        logic [7:0] biasTcfCpInitWord;
        logic [5:0] chargePumpInit;
        logic [5:0] chargePumpSteady;
        logic [3:0] loopResistorThreeSteady;
        logic [3:0] loopResistorThreeInit;
        logic [3:0] loopCapacitorThreeSteady;
        logic [3:0] loopCapacitorThreeInit;
        logic [3:0] loopCapacitorOne;
        logic [3:0] loopCapacitorTwo;
        logic [3:0] loopResistorOneSteady;
        logic [3:0] loopResistorOneInit;
        logic [2:0] varactorRefTcf;
        logic [3:0] oscOutputDivider;
        logic [7:0] calOffsetVarRefWord;
        logic [8:0] forcedTune;
        logic [6:0] amplitudeControlWord;
    } sflp_setup_t;
    typedef struct packed {
        logic [5:0] chargePump;
        logic [3:0] loopResistorOne;
        logic [3:0] loopResistorThree;
        logic [3:0] loopCapacitorThree;
        logic wideBandwidth;
    } sflp_loop_t;
endpackage
`default_nettype wire

// ===== sflp_store.sv
// Fast-lock profile store: eight profiles of sixteen bytes, host registers,
// recall into synthesizer setup and the timed wide-bandwidth phase.
// Assumes a host register port on the same clock with one-cycle strobes.
`default_nettype none
module sflp_store
    import sflp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output var sflp_setup_t synthSetup,
    output var sflp_loop_t loopActive,
    output logic fastLockEnabled,
    output logic [2:0] activeProfile
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstSync1_reg;
    logic rstSync2_reg;
    logic rstInt_n;
    // Reset asserts at once and is released on the clock through two stages.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstInt_n = rstSync2_reg;

    // ------------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------------
    logic [7:0] setup_reg, setup_next;
    logic [7:0] initDelay_reg, initDelay_next;
    logic [7:0] progAddr_reg, progAddr_next;
    logic [7:0] progData_reg, progData_next;
    logic [7:0] progCtrl_reg, progCtrl_next;
    logic [7:0] rdData_reg, rdData_next;
    logic rdValid_reg, rdValid_next;
    logic recallPending_reg, recallPending_next;
    logic [7:0] store [NUM_PROFILES][NUM_WORDS];
    logic addrValid;
    logic commit;
    logic [7:0] readBack;

    // Upper nibble 8 to F maps to no profile.
    assign addrValid = (progAddr_reg[7] == 1'b0);
    assign readBack = addrValid ? store[progAddr_reg[6:4]][progAddr_reg[3:0]] : 8'h00;
    // A pending write only commits while the program clock runs.
    assign commit = progCtrl_reg[CTRL_WRITE_BIT] && progCtrl_reg[CTRL_CLKEN_BIT];

    always_comb begin
        setup_next = setup_reg;
        initDelay_next = initDelay_reg;
        progAddr_next = progAddr_reg;
        progData_next = progData_reg;
        progCtrl_next = progCtrl_reg;
        rdData_next = rdData_reg;
        rdValid_next = 1'b0;
        recallPending_next = 1'b0;
        if (commit) begin
            progCtrl_next[CTRL_WRITE_BIT] = 1'b0;
        end
        if (regWrite) begin
            case (regAddr)
                OFS_SETUP: begin
                    setup_next = regWrData;
                    recallPending_next = regWrData[SETUP_ENABLE_BIT];
                end
                OFS_INIT_DELAY: initDelay_next = regWrData;
                OFS_PROG_ADDR: progAddr_next = regWrData;
                OFS_PROG_DATA: progData_next = regWrData;
                // A fresh host write to the control register wins over the self-clear.
                OFS_PROG_CTRL: progCtrl_next = regWrData & 8'h03;
                default: begin
                end
            endcase
        end
        if (regRead) begin
            rdValid_next = 1'b1;
            case (regAddr)
                OFS_SETUP: rdData_next = setup_reg;
                OFS_INIT_DELAY: rdData_next = initDelay_reg;
                OFS_PROG_ADDR: rdData_next = progAddr_reg;
                OFS_PROG_DATA: rdData_next = progData_reg;
                OFS_READ_BACK: rdData_next = readBack;
                OFS_PROG_CTRL: rdData_next = progCtrl_reg;
                default: rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstInt_n) begin
        if (!rstInt_n) begin
            setup_reg <= RST_SETUP;
            initDelay_reg <= RST_INIT_DELAY;
            progAddr_reg <= RST_PROG_ADDR;
            progData_reg <= RST_PROG_DATA;
            progCtrl_reg <= RST_PROG_CTRL;
            rdData_reg <= 8'h00;
            rdValid_reg <= 1'b0;
            recallPending_reg <= 1'b0;
        end else if (clockEnable) begin
            setup_reg <= setup_next;
            initDelay_reg <= initDelay_next;
            progAddr_reg <= progAddr_next;
            progData_reg <= progData_next;
            progCtrl_reg <= progCtrl_next;
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
            recallPending_reg <= recallPending_next;
        end
    end

    // ------------------------------------------------------------------
    // Profile memory
    // ------------------------------------------------------------------
    logic memWrEn_next;
    logic [2:0] memWrProfile_next;
    logic [3:0] memWrWord_next;
    logic [7:0] memWrData_next;

    // Only the addressed byte is written; all others keep their value.
    always_comb begin
        memWrEn_next = clockEnable && commit && addrValid;
        memWrProfile_next = progAddr_reg[6:4];
        memWrWord_next = progAddr_reg[3:0];
        memWrData_next = progData_reg;
    end

    always_ff @(posedge clock) begin
        if (memWrEn_next) begin
            store[memWrProfile_next][memWrWord_next] <= memWrData_next;
        end
    end

    // ------------------------------------------------------------------
    // Recall and wide-bandwidth timer
    // ------------------------------------------------------------------
    logic [7:0] words_reg [NUM_WORDS];
    logic [7:0] words_next [NUM_WORDS];
    logic [10:0] wideCount_reg, wideCount_next;
    logic [2:0] recallProfile;
    logic [10:0] wideLoad;

    assign recallProfile = setup_reg[SETUP_PROFILE_HI:SETUP_PROFILE_LO];
    // The longest delay, 255 steps of five cycles, still fits the 11-bit timer.
    assign wideLoad = 11'(initDelay_reg * INIT_STEP_CYCLES);

    always_comb begin
        for (int i = 0; i < NUM_WORDS; i++) begin
            words_next[i] = words_reg[i];
        end
        wideCount_next = wideCount_reg;
        if (wideCount_reg != 11'h000) begin
            wideCount_next = wideCount_reg - 11'h001;
        end
        if (recallPending_reg) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                words_next[i] = store[recallProfile][i];
            end
            wideCount_next = wideLoad;
        end
    end

    always_ff @(posedge clock or negedge rstInt_n) begin
        if (!rstInt_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                words_reg[i] <= 8'h00;
            end
            wideCount_reg <= 11'h000;
        end else if (clockEnable) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                words_reg[i] <= words_next[i];
            end
            wideCount_reg <= wideCount_next;
        end
    end

    // ------------------------------------------------------------------
    // Word unpacking
    // ------------------------------------------------------------------
    sflp_setup_t setupOut_reg, setupOut_next;

    // Decoded from the next words, so the registered fields change with the words.
    always_comb begin
        setupOut_next.integerWord = {words_next[1][2:0], words_next[0]};
        setupOut_next.fractionalWord = {words_next[4][6:0], words_next[3], words_next[2]};
        setupOut_next.oscBiasRef = words_next[5][6:4];
        setupOut_next.oscVaractor = words_next[5][3:0];
        setupOut_next.biasTcfCpInitWord = words_next[6];
        setupOut_next.chargePumpInit = words_next[6][5:0];
        setupOut_next.chargePumpSteady = words_next[7][5:0];
        setupOut_next.loopResistorThreeSteady = words_next[8][7:4];
        setupOut_next.loopResistorThreeInit = words_next[8][3:0];
        setupOut_next.loopCapacitorThreeSteady = words_next[9][7:4];
        setupOut_next.loopCapacitorThreeInit = words_next[9][3:0];
        setupOut_next.loopCapacitorOne = words_next[10][7:4];
        setupOut_next.loopCapacitorTwo = words_next[10][3:0];
        setupOut_next.loopResistorOneSteady = words_next[11][7:4];
        setupOut_next.loopResistorOneInit = words_next[11][3:0];
        setupOut_next.varactorRefTcf = words_next[12][6:4];
        setupOut_next.oscOutputDivider = words_next[12][3:0];
        setupOut_next.calOffsetVarRefWord = words_next[13];
        setupOut_next.forcedTune = {words_next[15][0], words_next[14]};
        setupOut_next.amplitudeControlWord = words_next[15][7:1];
    end

    always_ff @(posedge clock or negedge rstInt_n) begin
        if (!rstInt_n) begin
            setupOut_reg.integerWord <= 11'h000;
            setupOut_reg.fractionalWord <= 23'h000000;
            setupOut_reg.oscBiasRef <= 3'h0;
            setupOut_reg.oscVaractor <= 4'h0;
            setupOut_reg.biasTcfCpInitWord <= 8'h00;
            setupOut_reg.chargePumpInit <= 6'h00;
            setupOut_reg.chargePumpSteady <= 6'h00;
            setupOut_reg.loopResistorThreeSteady <= 4'h0;
            setupOut_reg.loopResistorThreeInit <= 4'h0;
            setupOut_reg.loopCapacitorThreeSteady <= 4'h0;
            setupOut_reg.loopCapacitorThreeInit <= 4'h0;
            setupOut_reg.loopCapacitorOne <= 4'h0;
            setupOut_reg.loopCapacitorTwo <= 4'h0;
            setupOut_reg.loopResistorOneSteady <= 4'h0;
            setupOut_reg.loopResistorOneInit <= 4'h0;
            setupOut_reg.varactorRefTcf <= 3'h0;
            setupOut_reg.oscOutputDivider <= 4'h0;
            setupOut_reg.calOffsetVarRefWord <= 8'h00;
            setupOut_reg.forcedTune <= 9'h000;
            setupOut_reg.amplitudeControlWord <= 7'h00;
        end else if (clockEnable) begin
            setupOut_reg <= setupOut_next;
        end
    end

    // ------------------------------------------------------------------
    // Applied loop values
    // ------------------------------------------------------------------
    sflp_loop_t loop_reg, loop_next;
    logic wideNext;

    // Wide values apply while the timer runs, then the steady ones. They are
    // chosen from the next words and count, so they switch with the recall.
    always_comb begin
        wideNext = (wideCount_next != 11'h000);
        loop_next.wideBandwidth = wideNext;
        loop_next.chargePump = wideNext ? words_next[6][5:0] : words_next[7][5:0];
        loop_next.loopResistorOne = wideNext ? words_next[11][3:0] : words_next[11][7:4];
        loop_next.loopResistorThree = wideNext ? words_next[8][3:0] : words_next[8][7:4];
        loop_next.loopCapacitorThree = wideNext ? words_next[9][3:0] : words_next[9][7:4];
    end

    always_ff @(posedge clock or negedge rstInt_n) begin
        if (!rstInt_n) begin
            loop_reg.chargePump <= 6'h00;
            loop_reg.loopResistorOne <= 4'h0;
            loop_reg.loopResistorThree <= 4'h0;
            loop_reg.loopCapacitorThree <= 4'h0;
            loop_reg.wideBandwidth <= 1'b0;
        end else if (clockEnable) begin
            loop_reg <= loop_next;
        end
    end

    assign regRdData = rdData_reg;
    assign regRdValid = rdValid_reg;
    assign synthSetup = setupOut_reg;
    assign loopActive = loop_reg;
    assign fastLockEnabled = setup_reg[SETUP_ENABLE_BIT];
    assign activeProfile = setup_reg[SETUP_PROFILE_HI:SETUP_PROFILE_LO];
endmodule
`default_nettype wire

// ===== sflp_store_chk.sv
// Checker for the profile store host port and applied loop values.
// Bound to sflp_store and sees only its ports; one clock domain.
`default_nettype none
module sflp_store_chk
    import sflp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire sflp_setup_t synthSetup,
    input wire sflp_loop_t loopActive,
    input wire logic fastLockEnabled,
    input wire logic [2:0] activeProfile
);
    // --------------------------------
    // Assertions
    // --------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic rdTake;
    logic setWr;
    logic recallReq;
    logic rdUnmapped;
    assign rdTake = regRead && clockEnable;
    assign setWr = regWrite && clockEnable && regAddr == OFS_SETUP;
    assign recallReq = setWr && regWrData[SETUP_ENABLE_BIT];
    assign rdUnmapped = rdTake && (regAddr < OFS_SETUP || regAddr > OFS_PROG_CTRL);
    a_read_answer: assert property (rdTake |=> regRdValid)
        else $error("read not answered");
    a_read_quiet: assert property (clockEnable && !regRead |=> !regRdValid)
        else $error("read valid without read");
    a_ctrl_bits: assert property (rdTake && regAddr == OFS_PROG_CTRL
        |=> regRdData[7:2] == 6'h00)
        else $error("control open bits set");
    a_unmapped_zero: assert property (rdUnmapped |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_setup_fields: assert property (setWr |=> fastLockEnabled == $past(regWrData[0])
        && activeProfile == $past(regWrData[7:5]))
        else $error("setup fields wrong");
    a_setup_hold: assert property (!setWr |=> $stable(fastLockEnabled)
        && $stable(activeProfile))
        else $error("setup changed without write");
    a_steady_loop: assert property (!loopActive.wideBandwidth |-> loopActive[18:1] ==
        {synthSetup.chargePumpSteady, synthSetup.loopResistorOneSteady,
        synthSetup.loopResistorThreeSteady, synthSetup.loopCapacitorThreeSteady})
        else $error("steady loop values wrong");
    a_wide_loop: assert property (loopActive.wideBandwidth |-> loopActive[18:1] ==
        {synthSetup.chargePumpInit, synthSetup.loopResistorOneInit,
        synthSetup.loopResistorThreeInit, synthSetup.loopCapacitorThreeInit})
        else $error("initial loop values wrong");
    a_recall_only: assert property ($changed(synthSetup) |-> $past(recallReq, 2))
        else $error("setup changed without recall");
    c_read_back: cover property (rdTake && regAddr == OFS_READ_BACK);
    c_recall: cover property (recallReq);
    c_wide: cover property (loopActive.wideBandwidth);
endmodule
bind sflp_store sflp_store_chk u_chk (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .synthSetup(synthSetup),
    .loopActive(loopActive), .fastLockEnabled(fastLockEnabled), .activeProfile(activeProfile));
`default_nettype wire

// ===== sflp_store_tb_top.sv
// Self-checking bench for the profile store host registers and recall.
// Drives the host port directly at 20 MHz; no partner model.
`default_nettype none
module sflp_store_tb_top
    import sflp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clockEnable = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic regRdValid;
    sflp_setup_t synthSetup;
    sflp_loop_t loopActive;
    logic fastLockEnabled;
    logic [2:0] activeProfile;
    int errorCnt = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [9:0] RST_OFS [5] = '{OFS_SETUP, OFS_INIT_DELAY, OFS_PROG_ADDR,
        OFS_PROG_DATA, OFS_PROG_CTRL};
    sflp_store dut (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .synthSetup(synthSetup),
        .loopActive(loopActive), .fastLockEnabled(fastLockEnabled), .activeProfile(activeProfile));
    initial forever #25 clock = ~clock;
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic end_of_test();
        if (errorCnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            errorCnt++;
            end_of_test();
        end
    end
    task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge clock);
        #5 regWrite = 1'b0;
        @(posedge clock);
        #5;
    endtask
    task automatic rd(logic [9:0] a, logic [7:0] e);
        regRead = 1'b1;
        regAddr = a;
        @(posedge clock);
        #5 regRead = 1'b0;
        check("regRdValid", regRdValid, 1'b1);
        check("regRdData", regRdData, e);
        @(posedge clock);
        #5;
    endtask
    task automatic prog(logic [3:0] p, logic [3:0] w, logic [7:0] d);
        wr(OFS_PROG_ADDR, {p, w});
        wr(OFS_PROG_DATA, d);
        wr(OFS_PROG_CTRL, 8'h03);
    endtask
    function automatic logic [7:0] pat(logic [3:0] p, logic [3:0] w);
        return ({p, w} * 8'h25) + 8'h5A;
    endfunction
    function automatic sflp_setup_t expSet(logic [3:0] p);
        logic [7:0] w [16];
        sflp_setup_t s;
        for (int i = 0; i < 16; i++) w[i] = pat(p, i[3:0]);
        s.integerWord = {w[1][2:0], w[0]};
        s.fractionalWord = {w[4][6:0], w[3], w[2]};
        {s.oscBiasRef, s.oscVaractor} = {w[5][6:4], w[5][3:0]};
        s.biasTcfCpInitWord = w[6];
        s.chargePumpInit = w[6][5:0];
        s.chargePumpSteady = w[7][5:0];
        {s.loopResistorThreeSteady, s.loopResistorThreeInit} = w[8];
        {s.loopCapacitorThreeSteady, s.loopCapacitorThreeInit} = w[9];
        {s.loopCapacitorOne, s.loopCapacitorTwo} = w[10];
        {s.loopResistorOneSteady, s.loopResistorOneInit} = w[11];
        {s.varactorRefTcf, s.oscOutputDivider} = {w[12][6:4], w[12][3:0]};
        s.calOffsetVarRefWord = w[13];
        s.forcedTune = {w[15][0], w[14]};
        s.amplitudeControlWord = w[15][7:1];
        return s;
    endfunction
    task automatic recall(logic [2:0] p, int wide);
        sflp_setup_t s;
        sflp_loop_t ini;
        sflp_loop_t steady;
        s = expSet({1'b0, p});
        ini = {s.chargePumpInit, s.loopResistorOneInit, s.loopResistorThreeInit,
            s.loopCapacitorThreeInit, 1'b1};
        steady = {s.chargePumpSteady, s.loopResistorOneSteady, s.loopResistorThreeSteady,
            s.loopCapacitorThreeSteady, 1'b0};
        regWrite = 1'b1;
        regAddr = OFS_SETUP;
        regWrData = {p, 5'h01};
        @(posedge clock);
        #5 regWrite = 1'b0;
        check("activeProfile", activeProfile, p);
        check("fastLockEnabled", fastLockEnabled, 1'b1);
        @(posedge clock);
        #5;
        check("synthSetup", synthSetup, s);
        for (int i = 0; i <= wide; i++) begin
            check("loopActive", loopActive, (i < wide) ? ini : steady);
            @(posedge clock);
            #5;
        end
    endtask
    // --------------------------------
    // Sequence
    // --------------------------------
    initial begin
        repeat (3) @(posedge clock);
        #5 rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #5;
        foreach (RST_OFS[i]) rd(RST_OFS[i], 8'h00);
        rd(10'h299, 8'h00);
        rd(10'h2A0, 8'h00);
        for (int w = 0; w < 16; w++) begin
            prog(4'h3, w[3:0], pat(4'h3, w[3:0]));
            prog(4'h5, w[3:0], pat(4'h5, w[3:0]));
            rd(OFS_READ_BACK, pat(4'h5, w[3:0]));
            rd(OFS_PROG_CTRL, 8'h01);
        end
        for (int w = 0; w < 16; w++) begin
            wr(OFS_PROG_ADDR, {4'h3, w[3:0]});
            rd(OFS_READ_BACK, pat(4'h3, w[3:0]));
        end
        prog(4'h8, 4'h0, 8'hAA);
        rd(OFS_READ_BACK, 8'h00);
        wr(OFS_PROG_ADDR, 8'h31);
        wr(OFS_READ_BACK, 8'h77);
        rd(OFS_READ_BACK, pat(4'h3, 4'h1));
        wr(OFS_PROG_DATA, 8'hC6);
        wr(OFS_PROG_CTRL, 8'h02);
        rd(OFS_PROG_CTRL, 8'h02);
        rd(OFS_READ_BACK, pat(4'h3, 4'h1));
        wr(OFS_PROG_CTRL, 8'hFF);
        rd(OFS_PROG_CTRL, 8'h01);
        rd(OFS_READ_BACK, 8'hC6);
        prog(4'h3, 4'h1, pat(4'h3, 4'h1));
        wr(OFS_PROG_CTRL, 8'hFC);
        rd(OFS_PROG_CTRL, 8'h00);
        wr(OFS_INIT_DELAY, 8'h02);
        rd(OFS_INIT_DELAY, 8'h02);
        recall(3'd3, 2 * INIT_STEP_CYCLES);
        wr(OFS_INIT_DELAY, 8'h00);
        recall(3'd5, 0);
        rd(OFS_SETUP, 8'hA1);
        wr(OFS_SETUP, 8'h00);
        check("fastLockEnabled", fastLockEnabled, 1'b0);
        clockEnable = 1'b0;
        regRead = 1'b1;
        @(posedge clock);
        #5 regRead = 1'b0;
        clockEnable = 1'b1;
        check("regRdValid", regRdValid, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
